// ==== tdt_timer.sv ====
`timescale 1ns/1ps
`include "tdt_defines.svh"
module tdt_timer
  import tdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic ext_clk_a,
  input wire logic ext_clk_b,
  input wire logic cpu_idle,
  output logic [15:0] timebase_lo,
  output logic [15:0] timebase_hi,
  output logic adc_trigger,
  output logic irq_first,
  output logic irq_period_match
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] ps_limit(input logic [1:0] sel);
    unique case (sel)
      2'b00: ps_limit = `TDT_PS1;
      2'b01: ps_limit = `TDT_PS8;
      2'b10: ps_limit = `TDT_PS64;
      2'b11: ps_limit = `TDT_PS256;
    endcase
  endfunction

  function automatic logic runs(input tdt_word_t c, input logic idle);
    runs = c[`TDT_B_ON] & ~(idle & c[`TDT_B_IDL]);
  endfunction

  // External clock, gated or ungated instruction cycle; no asynchronous mode.
  function automatic logic src_ok(input tdt_word_t c, input logic rise,
                                  input logic lvl);
    src_ok = c[`TDT_B_CS] ? rise : (c[`TDT_B_GATE] ? lvl : 1'b1);
  endfunction

  function automatic tdt_word_t merge(input tdt_word_t old,
                                      input logic [15:0] d,
                                      input logic [1:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  tdt_bus_e bus;
  logic ack;
  logic wr;
  logic cap;
  logic [31:0] next_rdata;
  tdt_word_t ctl_a, ctl_b, prd_lo, prd_hi, cnt_lo, cnt_hi, hold;
  logic flag_a, flag_b, en_a, en_b;

  assign ack = (bus == TDT_BUS_DONE);
  assign waitrequest = (read | write) & ~ack;
  assign wr = write & ack;
  assign cap = read & ~ack;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus <= TDT_BUS_WAIT;
    end else begin
      unique case (bus)
        TDT_BUS_WAIT: if (read | write) bus <= TDT_BUS_DONE;
        TDT_BUS_DONE: bus <= TDT_BUS_WAIT;
      endcase
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (address)
      `TDT_IDX_LOW: next_rdata[15:0] = cnt_lo;
      `TDT_IDX_HOLD: next_rdata[15:0] = hold;
      `TDT_IDX_HIGH: next_rdata[15:0] = cnt_hi;
      `TDT_IDX_PRLO: next_rdata[15:0] = prd_lo;
      `TDT_IDX_PRHI: next_rdata[15:0] = prd_hi;
      `TDT_IDX_CTLA: next_rdata[15:0] = ctl_a;
      `TDT_IDX_CTLB: next_rdata[15:0] = ctl_b;
      `TDT_IDX_IRQ: next_rdata[3:0] = {en_b, en_a, flag_b, flag_a};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) readdata <= 32'h0000_0000;
    else if (cap) readdata <= next_rdata;
  end

  logic wr_low, wr_high, wr_irq;
  assign wr_low = wr & (address == `TDT_IDX_LOW);
  assign wr_high = wr & (address == `TDT_IDX_HIGH);
  assign wr_irq = wr & (address == `TDT_IDX_IRQ) & byteenable[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_a <= `TDT_ZERO16;
      ctl_b <= `TDT_ZERO16;
      prd_lo <= `TDT_PR_RST;
      prd_hi <= `TDT_PR_RST;
    end else if (wr) begin
      unique case (address)
        `TDT_IDX_CTLA: ctl_a <= merge(ctl_a, writedata[15:0],
                                      byteenable[1:0]) & `TDT_CTLA_MASK;
        `TDT_IDX_CTLB: ctl_b <= merge(ctl_b, writedata[15:0],
                                      byteenable[1:0]) & `TDT_CTLB_MASK;
        `TDT_IDX_PRLO: prd_lo <= merge(prd_lo, writedata[15:0],
                                       byteenable[1:0]);
        `TDT_IDX_PRHI: prd_hi <= merge(prd_hi, writedata[15:0],
                                       byteenable[1:0]);
        default: ;
      endcase
    end
  end

  // Latched with the read data so the pair is taken in one cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hold <= `TDT_ZERO16;
    else if (cap && address == `TDT_IDX_LOW) hold <= cnt_hi;
    else if (wr && address == `TDT_IDX_HOLD)
      hold <= merge(hold, writedata[15:0], byteenable[1:0]);
  end

  // ----------------------------------------
  // Inputs and prescalers
  // ----------------------------------------
  logic m32, ext_a_q, ext_b_q, rise_a, rise_b, fall_a, fall_b;
  logic run_a, run_b, pre_a, pre_b, tick_a_raw, tick_a, tick_b;
  logic inc_a, inc_b;
  logic [7:0] ps_a, ps_b;

  assign m32 = ctl_a[`TDT_B_M32];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_a_q <= 1'b0;
      ext_b_q <= 1'b0;
    end else begin
      ext_a_q <= ext_clk_a;
      ext_b_q <= ext_clk_b;
    end
  end
  assign rise_a = ext_clk_a & ~ext_a_q;
  assign rise_b = ext_clk_b & ~ext_b_q;
  assign fall_a = ~ext_clk_a & ext_a_q;
  assign fall_b = ~ext_clk_b & ext_b_q;

  assign run_a = runs(ctl_a, cpu_idle);
  assign run_b = ~m32 & runs(ctl_b, cpu_idle);
  assign pre_a = run_a & src_ok(ctl_a, rise_a, ext_clk_a);
  assign pre_b = run_b & src_ok(ctl_b, rise_b, ext_clk_b);
  assign tick_a_raw = pre_a &
    (ps_a == ps_limit(ctl_a[`TDT_B_PSH:`TDT_B_PSL]));
  assign tick_b = pre_b &
    (ps_b == ps_limit(ctl_b[`TDT_B_PSH:`TDT_B_PSL]));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ps_a <= `TDT_ZERO8;
    else if (wr_low || !ctl_a[`TDT_B_ON] || tick_a_raw) ps_a <= `TDT_ZERO8;
    else if (pre_a) ps_a <= ps_a + `TDT_ONE8;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ps_b <= `TDT_ZERO8;
    else if (wr_high || !ctl_b[`TDT_B_ON] || tick_b) ps_b <= `TDT_ZERO8;
    else if (pre_b) ps_b <= ps_b + `TDT_ONE8;
  end

  // One register stage retimes a fast external prescaler output.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tick_a <= 1'b0;
    else tick_a <= tick_a_raw;
  end
  assign inc_a = tick_a & run_a;
  assign inc_b = tick_b;

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  logic match32, wrap_lo, ev_a, ev_pm, gf_a, gf_b;
  assign match32 = {cnt_hi, cnt_lo} == {prd_hi, prd_lo};
  assign wrap_lo = m32 ? match32 : (cnt_lo == prd_lo);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_lo <= `TDT_ZERO16;
    else if (wr_low) cnt_lo <= merge(cnt_lo, writedata[15:0],
                                     byteenable[1:0]);
    else if (inc_a) cnt_lo <= wrap_lo ? `TDT_ZERO16
                                      : cnt_lo + `TDT_ONE16;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_hi <= `TDT_ZERO16;
    else if (wr_high) cnt_hi <= merge(cnt_hi, writedata[15:0],
                                      byteenable[1:0]);
    else if (wr_low && m32) cnt_hi <= hold;
    else if (m32 && inc_a) begin
      if (match32) cnt_hi <= `TDT_ZERO16;
      else if (cnt_lo == `TDT_PR_RST) cnt_hi <= cnt_hi + `TDT_ONE16;
    end else if (inc_b) begin
      cnt_hi <= (cnt_hi == prd_hi) ? `TDT_ZERO16 : cnt_hi + `TDT_ONE16;
    end
  end

  assign timebase_lo = cnt_lo;
  assign timebase_hi = cnt_hi;

  // ----------------------------------------
  // Events and flags
  // ----------------------------------------
  // A gate drop ends accumulation and sets a flag; the count is left as it is.
  assign gf_a = ctl_a[`TDT_B_ON] & ctl_a[`TDT_B_GATE] &
                ~ctl_a[`TDT_B_CS] & fall_a;
  assign gf_b = run_b & ctl_b[`TDT_B_GATE] & ~ctl_b[`TDT_B_CS] & fall_b;
  assign ev_a = ~m32 & inc_a & (cnt_lo == prd_lo);
  assign ev_pm = m32 ? (inc_a & match32) : (inc_b & (cnt_hi == prd_hi));

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_a <= 1'b0;
      flag_b <= 1'b0;
      en_a <= 1'b0;
      en_b <= 1'b0;
    end else begin
      if (ev_a || (!m32 && gf_a)) flag_a <= 1'b1;
      else if (wr_irq && writedata[`TDT_B_FA]) flag_a <= 1'b0;
      if (ev_pm || (m32 && gf_a) || gf_b) flag_b <= 1'b1;
      else if (wr_irq && writedata[`TDT_B_FB]) flag_b <= 1'b0;
      if (wr_irq) begin
        en_a <= writedata[`TDT_B_EA];
        en_b <= writedata[`TDT_B_EB];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) adc_trigger <= 1'b0;
    else adc_trigger <= m32 & ev_pm;
  end

  assign irq_first = flag_a & en_a;
  assign irq_period_match = flag_b & en_b;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_wrap_to_zero: assert property (
    m32 && inc_a && match32 && !wr |=> cnt_lo == 16'h0000 &&
      cnt_hi == 16'h0000) else $error("32-bit count did not wrap");
  a_hold_latch: assert property (
    cap && address == `TDT_IDX_LOW |=> hold == $past(cnt_hi))
    else $error("holding word not latched on low read");
  a_hold_to_high: assert property (
    wr_low && m32 |=> cnt_hi == $past(hold))
    else $error("high word not loaded from holding");
  a_flag_sticky: assert property (
    flag_b && !(wr_irq && writedata[`TDT_B_FB]) |=> flag_b)
    else $error("period flag dropped without software clear");
  a_match_flag: assert property (
    ev_pm |=> flag_b) else $error("period match did not set flag");
  a_adc_pulse: assert property (
    m32 && inc_a && match32 |=> adc_trigger)
    else $error("converter trigger missing on period match");
  a_idle_freeze: assert property (
    m32 && cpu_idle && ctl_a[`TDT_B_IDL] && !wr ##1 !wr
      |-> $stable(cnt_lo) && $stable(cnt_hi))
    else $error("count moved in idle with idle stop set");
  a_ctlb_ignored: assert property (
    m32 && !ctl_a[`TDT_B_ON] && !wr |=> $stable(cnt_hi))
    else $error("high word moved while first timer off");
  a_resync_delay: assert property (
    inc_a |-> $past(tick_a_raw))
    else $error("first timer counted without retimed tick");

  c_wrap32: cover property (m32 && inc_a && match32);
  c_gate_fall: cover property (gf_a ##1 flag_b);
  c_coherent: cover property (cap && address == `TDT_IDX_LOW ##2
    cap && address == `TDT_IDX_HOLD);
endmodule

// ==== tdt_defines.svh ====
`ifndef TDT_DEFINES_SVH
`define TDT_DEFINES_SVH
// ----------------------------------------
// Register indexes (byte address = 4 x index)
// ----------------------------------------
`define TDT_IDX_LOW 9'h106
`define TDT_IDX_HOLD 9'h108
`define TDT_IDX_HIGH 9'h10A
`define TDT_IDX_PRLO 9'h10C
`define TDT_IDX_PRHI 9'h10E
`define TDT_IDX_CTLA 9'h110
`define TDT_IDX_CTLB 9'h112
`define TDT_IDX_IRQ 9'h120
// ----------------------------------------
// Control fields
// ----------------------------------------
`define TDT_B_ON 15
`define TDT_B_IDL 13
`define TDT_B_GATE 6
`define TDT_B_PSH 5
`define TDT_B_PSL 4
`define TDT_B_M32 3
`define TDT_B_CS 1
`define TDT_CTLA_MASK 16'hA07A
`define TDT_CTLB_MASK 16'hA072
// ----------------------------------------
// Interrupt register fields
// ----------------------------------------
`define TDT_B_FA 0
`define TDT_B_FB 1
`define TDT_B_EA 2
`define TDT_B_EB 3
// ----------------------------------------
// Reset values and prescaler limits
// ----------------------------------------
`define TDT_ZERO16 16'h0000
`define TDT_ONE16 16'h0001
`define TDT_PR_RST 16'hFFFF
`define TDT_ZERO8 8'h00
`define TDT_ONE8 8'h01
`define TDT_PS1 8'h00
`define TDT_PS8 8'h07
`define TDT_PS64 8'h3F
`define TDT_PS256 8'hFF
`endif

// ==== tdt_pkg.sv ====
package tdt_pkg;
  typedef logic [15:0] tdt_word_t;
  typedef enum logic {
    TDT_BUS_WAIT = 1'b0,
    TDT_BUS_DONE = 1'b1
  } tdt_bus_e;
endpackage

// ==== tdt_edge_src.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// External clock or gate source for the timer's counter inputs
// ----------------------------------------
// The line rests low between bursts, so no stray edge is ever counted.
module tdt_edge_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] n,
  input wire logic [7:0] half,
  output logic ext,
  output logic busy
);
  logic [8:0] left;
  logic [7:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext <= 1'b0;
      busy <= 1'b0;
      left <= 9'h000;
      cnt <= 8'h00;
    end else if (go && !busy) begin
      busy <= 1'b1;
      ext <= 1'b1;
      left <= {n, 1'b0} - 9'h001;
      cnt <= half;
    end else if (busy) begin
      if (cnt > 8'h01) begin
        cnt <= cnt - 8'h01;
      end else begin
        cnt <= half;
        if (left == 9'h000) begin
          busy <= 1'b0;
          ext <= 1'b0;
        end else begin
          ext <= ~ext;
          left <= left - 9'h001;
        end
      end
    end
  end
endmodule

// ==== cascadable_dual_timer_32bit_tb.sv ====
`timescale 1ns/1ps
`include "tdt_defines.svh"
module cascadable_dual_timer_32bit_tb;
  import tdt_pkg::*;
  logic clk = 0, rst = 1, read = 0, write = 0, cpu_idle = 0;
  logic [8:0] address = 0;
  logic [3:0] byteenable = 0;
  logic [31:0] writedata = 0, readdata;
  logic waitrequest, ext_a, ext_b, go_a = 0, go_b = 0, busy_a, busy_b;
  logic [7:0] n_e = 0, h_e = 1;
  logic [15:0] tb_lo, tb_hi;
  logic adc, irq1, irqp;
  int n_mismatch = 0, checked = 0;
  logic [31:0] seed = 32'h0000DD89;
  always #4 clk = ~clk;
  tdt_timer dut_u (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .ext_clk_a(ext_a),
    .ext_clk_b(ext_b), .cpu_idle(cpu_idle), .timebase_lo(tb_lo),
    .timebase_hi(tb_hi), .adc_trigger(adc), .irq_first(irq1),
    .irq_period_match(irqp));
  tdt_edge_src src_a (.clk(clk), .rst(rst), .go(go_a), .n(n_e),
    .half(h_e), .ext(ext_a), .busy(busy_a));
  tdt_edge_src src_b (.clk(clk), .rst(rst), .go(go_b), .n(n_e),
    .half(h_e), .ext(ext_b), .busy(busy_b));
  // ----------------------------------------
  // Expectations and checking
  // ----------------------------------------
  function logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic int ratio(input logic [1:0] s);
    return (s == 2'h0) ? 1 : (s == 2'h1) ? 8 : (s == 2'h2) ? 64 : 256;
  endfunction
  task tally_and_finish;
    $display("Counts: checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checked++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task tmo;
    n_mismatch++;
    $display("CHECK FAILED wait expected done seen timeout");
    tally_and_finish;
  endtask
  // ----------------------------------------
  // Bus cycles and waits
  // ----------------------------------------
  task bus(input logic w, input logic [8:0] a, input logic [15:0] d,
    output logic [15:0] q);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= {16'h0000, d};
    byteenable <= 4'hF;
    write <= w;
    read <= ~w;
    n = 0;
    // Waitrequest and read data are seen as they stood before this edge.
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) tmo;
    q = readdata[15:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task wr(input logic [8:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input logic [8:0] a, output logic [15:0] q);
    bus(1'b0, a, 16'h0000, q);
  endtask
  task pulses(input logic b, input logic [7:0] k, input logic [7:0] h);
    int n;
    @(posedge clk);
    n_e <= k;
    h_e <= h;
    go_a <= ~b;
    go_b <= b;
    @(posedge clk);
    go_a <= 1'b0;
    go_b <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((busy_a | busy_b) !== 1'b0 && n < 2000);
    if (n >= 2000) tmo;
    repeat (6) @(negedge clk);
  endtask
  task gap(output int g);
    logic [15:0] v;
    int n;
    @(negedge clk);
    v = tb_hi;
    n = 0;
    while (tb_hi === v && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (n >= 600) tmo;
    v = tb_hi;
    g = 0;
    while (tb_hi === v && g < 600) begin
      @(negedge clk);
      g++;
    end
    if (g >= 600) tmo;
  endtask
  task wait_adc(output int g);
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (adc !== 1'b1 && g < 1000);
    if (g >= 1000) tmo;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] q, h, l, v;
    int g, p, k;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`TDT_IDX_PRLO, q);
    chk("period_low", q, 16'hFFFF);
    wr(9'h0FF, rnd());
    rd(9'h0FF, q);
    chk("unmapped", q, 16'h0000);
    rd(`TDT_IDX_CTLA, q);
    chk("ctrl_reset", q, 16'h0000);
    $display("test reset done");
    wr(`TDT_IDX_CTLA, 16'h0008);
    h = rnd();
    l = rnd();
    wr(`TDT_IDX_HOLD, h);
    wr(`TDT_IDX_LOW, l);
    rd(`TDT_IDX_HIGH, q);
    chk("high_from_hold", q, h);
    chk("timebase", {tb_hi, tb_lo}, {h, l});
    v = rnd();
    wr(`TDT_IDX_HOLD, v);
    rd(`TDT_IDX_HOLD, q);
    chk("hold_written", q, v);
    rd(`TDT_IDX_LOW, q);
    rd(`TDT_IDX_HOLD, q);
    chk("hold_latched", q, h);
    $display("test holding done");
    wr(`TDT_IDX_CTLA, 16'h0000);
    for (k = 0; k < 4; k++) begin
      wr(`TDT_IDX_CTLB, 16'h8000 | 16'(k << 4));
      gap(g);
      chk("prescale_gap", g, ratio(k[1:0]));
    end
    wr(`TDT_IDX_CTLB, 16'h8002);
    wr(`TDT_IDX_HIGH, 16'h0000);
    k = rnd() % 20 + 1;
    pulses(1'b1, k[7:0], 8'h03);
    chk("split_count_b", tb_hi, k);
    $display("test prescaler done");
    wr(`TDT_IDX_CTLB, 16'h8030);
    wr(`TDT_IDX_CTLA, 16'h800A);
    wr(`TDT_IDX_HOLD, 16'h0000);
    wr(`TDT_IDX_LOW, 16'h0000);
    k = rnd() % 20 + 1;
    pulses(1'b0, k[7:0], 8'h03);
    chk("sync_count", {tb_hi, tb_lo}, k);
    @(posedge clk);
    cpu_idle <= 1'b1;
    wr(`TDT_IDX_CTLA, 16'hA00A);
    v = tb_lo;
    pulses(1'b0, 8'h05, 8'h03);
    chk("idle_frozen", tb_lo, v);
    wr(`TDT_IDX_CTLA, 16'h800A);
    pulses(1'b0, 8'h05, 8'h03);
    chk("idle_running", tb_lo, v + 16'h0005);
    @(posedge clk);
    cpu_idle <= 1'b0;
    $display("test counter done");
    wr(`TDT_IDX_IRQ, 16'h0007);
    wr(`TDT_IDX_CTLA, 16'h0000);
    wr(`TDT_IDX_LOW, 16'h0000);
    wr(`TDT_IDX_CTLA, 16'h8040);
    pulses(1'b0, 8'h01, 8'h14);
    v = tb_lo;
    repeat (10) @(negedge clk);
    chk("gate_kept", tb_lo, v);
    chk("gate_nonzero", v !== 16'h0000, 1'b1);
    chk("gate_flag", irq1, 1'b1);
    wr(`TDT_IDX_IRQ, 16'h0005);
    rd(`TDT_IDX_IRQ, q);
    chk("flag_cleared", {q[0], irq1}, 2'b00);
    $display("test gate done");
    wr(`TDT_IDX_CTLB, 16'h0000);
    wr(`TDT_IDX_CTLA, 16'h0008);
    p = rnd() % 16 + 3;
    wr(`TDT_IDX_PRHI, 16'h0000);
    wr(`TDT_IDX_PRLO, p[15:0]);
    wr(`TDT_IDX_HOLD, 16'h0000);
    wr(`TDT_IDX_LOW, 16'h0000);
    wr(`TDT_IDX_IRQ, 16'h000B);
    wr(`TDT_IDX_CTLA, 16'h8008);
    wait_adc(g);
    wait_adc(g);
    chk("wrap_interval", g, p + 1);
    chk("high_word", tb_hi, 16'h0000);
    chk("period_irq", irqp, 1'b1);
    rd(`TDT_IDX_IRQ, q);
    chk("flag_bits", q[1:0], 2'b10);
    $display("test period done");
    tally_and_finish;
  end
endmodule
